// >>> logic/byte_op_instruction_decoder.v
// byte-op instruction decoder and execute stage for an 8-bit core.
// assumes program memory on ref_clk_i hands one 16-bit word per valid
// cycle, and the data file answers file_rd_addr_o in the same cycle.
//
// Summary of operation
// - d=0 writes result to working register, d=1 back to file register
// - a=0 forces access bank, a=1 takes bank from bank select register
// - byte and bit formats carry an 8-bit file address in low byte
// - file move: two words, 12-bit source then 1111-prefixed 12-bit destination
// - bit formats carry a 3-bit bit position, access bit and address
// - literal formats carry an 8-bit immediate in the low byte
// - goto and call target: bits 7:0 first word, 19:8 second word
// - call word has one fast bit choosing shadow saving
// - fast bit 1 saves to shadow registers, 0 leaves shadows untouched
// - unconditional relative branch offset is bits 10:0
// - conditional branch offset is bits 7:0
// - add and add-with-carry update C, DC, Z, OV, N in one cycle
// - and, or, xor, complement take one cycle, update only Z and N
// - compare-skip on equal, greater, less; flags untouched
// - increment/decrement-skip on zero or nonzero, no flags, 1 to 3 cycles
// - rotates through carry update C, Z, N; plain rotates Z, N
// - subtracts update C, DC, Z, OV, N in one cycle
// - multiply takes one cycle and changes no flags
// - product lands in product high and product low byte registers
// - read-modify-write of the port reads pin levels, not the latch
// - write to timer0 count clears its prescaler when assigned
// - pc change or true test costs a second cycle run as nop; here only taken branches and skips flush, goto and call flush nothing
// - lone second words decode as nop
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "decoder_defines.vh"

module byte_op_instruction_decoder (
  // clock and reset
  input wire ref_clk_i,
  input wire reset_i,
  // program memory words
  input wire [15:0] instr_word_i,
  input wire instr_valid_i,
  // data file
  output reg [11:0] file_rd_addr_o,
  input wire [7:0] file_rd_data_i,
  output reg file_wr_en_o,
  output reg [11:0] file_wr_addr_o,
  output reg [7:0] file_wr_data_o,
  // port pins, asynchronous
  input wire [7:0] port_pins_i,
  // program flow
  output reg pc_abs_load_o,
  output reg [19:0] pc_target_o,
  output reg pc_rel_load_o,
  output reg [10:0] pc_offset_o,
  output reg call_push_o,
  output reg nop_cycle_o,
  output reg prescaler_clear_o,
  // apb slave
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output reg pready_o,
  output reg pslverr_o
);

  // ----------------------------------------------------------------
  // state encoding
  // ----------------------------------------------------------------
  localparam ST_NORMAL = 2'b01;
  localparam ST_WAIT2 = 2'b10;

  reg [1:0] state_q;
  reg exec_valid_q;
  reg [15:0] exec_word_q;
  reg [15:0] first_word_q;
  reg [1:0] kill_cnt_q;
  reg kill_ext_q;
  reg [7:0] working_register_q;
  reg [3:0] bank_select_register_q;
  reg [4:0] flags_q;
  reg [7:0] product_high_byte_q;
  reg [7:0] product_low_byte_q;
  reg [7:0] shadow_work_q;
  reg [3:0] shadow_bank_q;
  reg [4:0] shadow_flags_q;
  reg prescaler_assigned_q;
  reg [7:0] pins_meta_q;
  reg [7:0] pins_sync_q;

  // maps an 8-bit file field and access bit to a 12-bit data address
  function [11:0] bank_addr;
    input [7:0] f;
    input a;
    input [3:0] bank;
    begin
      if (a) begin
        bank_addr = {bank, f};
      end else if (f < `ACCESS_SPLIT) begin
        bank_addr = {`ACCESS_LOW_BANK, f};
      end else begin
        bank_addr = {`ACCESS_HIGH_BANK, f};
      end
    end
  endfunction

  // first words whose next word is an operand extension
  function is_two_word;
    input [15:0] w;
    begin
      is_two_word = (w[15:12] == `PFX_MOVE) || (w[15:9] == `PFX_CALL) ||
                    (w[15:8] == `PFX_GOTO) || (w[15:8] == `PFX_LOAD_PTR);
    end
  endfunction

  // ----------------------------------------------------------------
  // operand fetch
  // ----------------------------------------------------------------
  // the write of the previous instruction is still in flight when the
  // next one reads, so its data is forwarded to avoid a stale operand
  wire fwd_hit = file_wr_en_o && (file_wr_addr_o == file_rd_addr_o);
  wire port_hit = (file_rd_addr_o == `PORT_ADDR);
  wire [7:0] opnd = port_hit ? pins_sync_q :
                    fwd_hit ? file_wr_data_o : file_rd_data_i;
  wire [7:0] w = working_register_q;
  wire [5:0] op = exec_word_q[15:10];
  wire dbit = exec_word_q[9];
  wire [2:0] bit_pos = exec_word_q[11:9];
  wire [7:0] literal = exec_word_q[7:0];
  wire [15:0] prod = w * opnd;
  wire consume = (state_q == ST_WAIT2) && (exec_word_q[15:12] == `PFX_SECOND);

  // ----------------------------------------------------------------
  // shared adder for add, subtract, increment, decrement, negate
  // ----------------------------------------------------------------
  reg [7:0] add_x;
  reg [7:0] add_y;
  reg add_cin;
  wire [8:0] sum = {1'b0, add_x} + {1'b0, add_y} + {8'h00, add_cin};
  wire [4:0] nib = {1'b0, add_x[3:0]} + {1'b0, add_y[3:0]} + {4'h0, add_cin};
  wire add_ovf = (add_x[7] == add_y[7]) && (sum[7] != add_x[7]);

  // ----------------------------------------------------------------
  // execute decode
  // ----------------------------------------------------------------
  reg [7:0] res;
  reg wr_file;
  reg wr_work;
  reg [4:0] fmask;
  reg rot_sel;
  reg rot_c;
  reg skip;
  reg do_mul;
  reg rel_load;
  reg [10:0] rel_off;

  // one instruction per cycle; skip and branch tests settle here
  always @* begin
    add_x = opnd;
    add_y = w;
    add_cin = 1'b0;
    res = opnd;
    wr_file = 1'b0;
    wr_work = 1'b0;
    fmask = `MASK_NONE;
    rot_sel = 1'b0;
    rot_c = 1'b0;
    skip = 1'b0;
    do_mul = 1'b0;
    rel_load = 1'b0;
    rel_off = {{3{literal[7]}}, literal};
    if (exec_valid_q && !consume) begin
      case (op)
        `OP_MISC: begin
          do_mul = dbit;
        end
        `OP_DECF: begin
          add_y = `ONES8;
          res = sum[7:0];
          fmask = `MASK_ALL;
        end
        `OP_IOR: begin
          res = opnd | w;
          fmask = `MASK_ZN;
        end
        `OP_AND: begin
          res = opnd & w;
          fmask = `MASK_ZN;
        end
        `OP_XOR: begin
          res = opnd ^ w;
          fmask = `MASK_ZN;
        end
        `OP_COMPLEMENT_FILE: begin
          res = ~opnd;
          fmask = `MASK_ZN;
        end
        `OP_ADDC, `OP_ADD: begin
          add_cin = (op == `OP_ADDC) ? flags_q[`FLG_C] : 1'b0;
          res = sum[7:0];
          fmask = `MASK_ALL;
        end
        `OP_INCF: begin
          add_y = `RST_BYTE;
          add_cin = 1'b1;
          res = sum[7:0];
          fmask = `MASK_ALL;
        end
        `OP_DECSZ, `OP_DECSNZ: begin
          add_y = `ONES8;
          res = sum[7:0];
          skip = (op == `OP_DECSZ) ? (sum[7:0] == `RST_BYTE) : (sum[7:0] != `RST_BYTE);
        end
        `OP_INCSZ, `OP_INCSNZ: begin
          add_y = `RST_BYTE;
          add_cin = 1'b1;
          res = sum[7:0];
          skip = (op == `OP_INCSZ) ? (sum[7:0] == `RST_BYTE) : (sum[7:0] != `RST_BYTE);
        end
        `OP_RRC: begin
          res = {flags_q[`FLG_C], opnd[7:1]};
          rot_sel = 1'b1;
          rot_c = opnd[0];
          fmask = `MASK_CZN;
        end
        `OP_RLC: begin
          res = {opnd[6:0], flags_q[`FLG_C]};
          rot_sel = 1'b1;
          rot_c = opnd[7];
          fmask = `MASK_CZN;
        end
        `OP_SWAP: begin
          res = {opnd[3:0], opnd[7:4]};
        end
        `OP_RRN: begin
          res = {opnd[0], opnd[7:1]};
          fmask = `MASK_ZN;
        end
        `OP_RLN: begin
          res = {opnd[6:0], opnd[7]};
          fmask = `MASK_ZN;
        end
        `OP_MOVF: begin
          fmask = `MASK_ZN;
        end
        `OP_SUBTRACT_FILE_FROM_WORK_BORROW: begin
          add_x = w;
          add_y = ~opnd;
          add_cin = flags_q[`FLG_C];
          res = sum[7:0];
          fmask = `MASK_ALL;
        end
        `OP_SUBTRACT_WORK_FROM_FILE_BORROW, `OP_SUBTRACT_WORK_FROM_FILE: begin
          add_y = ~w;
          add_cin = (op == `OP_SUBTRACT_WORK_FROM_FILE) ? 1'b1 : flags_q[`FLG_C];
          res = sum[7:0];
          fmask = `MASK_ALL;
        end
        default: begin
          res = opnd;
        end
      endcase
      // destination select for the d-carrying groups; misc and literal words carry no d bit
      if (exec_word_q[15:12] < `PFX_GROUP6 && (op == `OP_DECF || op > `OP_LIT_LAST)) begin
        wr_file = dbit;
        wr_work = !dbit;
      end
      // single-operand group: compares, test, set, clear, negate, store
      if (exec_word_q[15:12] == `PFX_GROUP6) begin
        case (bit_pos)
          `G6_CPLT: skip = opnd < w;
          `G6_CPEQ: skip = opnd == w;
          `G6_CPGT: skip = opnd > w;
          `G6_TSTZ: skip = opnd == `RST_BYTE;
          `G6_SETF: begin
            res = `ONES8;
            wr_file = 1'b1;
          end
          `G6_CLRF: begin
            res = `RST_BYTE;
            wr_file = 1'b1;
            fmask = `MASK_Z;
          end
          `G6_NEGF: begin
            add_x = `RST_BYTE;
            add_y = ~opnd;
            add_cin = 1'b1;
            res = sum[7:0];
            wr_file = 1'b1;
            fmask = `MASK_ALL;
          end
          `G6_MOVWF: begin
            res = w;
            wr_file = 1'b1;
          end
          default: res = opnd;
        endcase
      end
      // relative branches: always and conditional on a flag
      if (exec_word_q[15:11] == `PFX_BRANCH_ALWAYS) begin
        rel_load = 1'b1;
        rel_off = exec_word_q[10:0];
      end
      if (exec_word_q[15:11] == `PFX_COND_BRANCH) begin
        case (exec_word_q[10:9])
          2'h0: rel_load = flags_q[`FLG_Z] ^ exec_word_q[8];
          2'h1: rel_load = flags_q[`FLG_C] ^ exec_word_q[8];
          2'h2: rel_load = flags_q[`FLG_OVF] ^ exec_word_q[8];
          default: rel_load = flags_q[`FLG_N] ^ exec_word_q[8];
        endcase
      end
    end
  end

  // new flag values before masking
  wire [4:0] new_flags = {res[7], add_ovf, (res == `RST_BYTE), nib[4], (rot_sel ? rot_c : sum[8])};

  // ----------------------------------------------------------------
  // flush control
  // ----------------------------------------------------------------
  // a taken skip or branch discards the word already fetched; a skip
  // landing on a two-word first word extends the flush over both
  wire kill_now = rel_load || skip;
  wire [1:0] eff_cnt = kill_now ? `KILL_ONE : kill_cnt_q;
  wire eff_ext = kill_now ? skip : kill_ext_q;
  wire discard = instr_valid_i && (eff_cnt != `KILL_NONE);
  wire [1:0] cnt_after = eff_cnt - `KILL_ONE + {1'b0, eff_ext && is_two_word(instr_word_i)};

  // first words that hand over to a second word in this cycle
  wire start_two = exec_valid_q && !consume && is_two_word(exec_word_q);
  wire write_file = wr_file || (consume && first_word_q[15:12] == `PFX_MOVE);
  wire [11:0] wr_addr = consume ? exec_word_q[11:0] : file_rd_addr_o;
  wire apb_access = psel_i && penable_i && pready_o;
  wire apb_wr = apb_access && pwrite_i;

  // ----------------------------------------------------------------
  // port pin synchroniser
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pins_meta_q <= `RST_BYTE;
      pins_sync_q <= `RST_BYTE;
    end else begin
      pins_meta_q <= port_pins_i;
      pins_sync_q <= pins_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // pipeline, architectural state and outputs
  // ----------------------------------------------------------------
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      state_q <= ST_NORMAL;
      exec_valid_q <= 1'b0;
      exec_word_q <= `RST_WORD;
      first_word_q <= `RST_WORD;
      kill_cnt_q <= `KILL_NONE;
      kill_ext_q <= 1'b0;
      working_register_q <= `RST_BYTE;
      bank_select_register_q <= `RST_BANK;
      flags_q <= `RST_FLAGS;
      product_high_byte_q <= `RST_BYTE;
      product_low_byte_q <= `RST_BYTE;
      shadow_work_q <= `RST_BYTE;
      shadow_bank_q <= `RST_BANK;
      shadow_flags_q <= `RST_FLAGS;
      file_rd_addr_o <= `RST_ADDR;
      file_wr_en_o <= 1'b0;
      file_wr_addr_o <= `RST_ADDR;
      file_wr_data_o <= `RST_BYTE;
      pc_abs_load_o <= 1'b0;
      pc_target_o <= `RST_TARGET;
      pc_rel_load_o <= 1'b0;
      pc_offset_o <= `RST_OFFSET;
      call_push_o <= 1'b0;
      nop_cycle_o <= 1'b0;
      prescaler_clear_o <= 1'b0;
    end else begin
      // accept the next word; a flushed word runs as a nop cycle
      exec_valid_q <= instr_valid_i && !discard;
      nop_cycle_o <= discard;
      if (instr_valid_i) begin
        exec_word_q <= instr_word_i;
        kill_cnt_q <= discard ? cnt_after : `KILL_NONE;
        kill_ext_q <= 1'b0;
      end else begin
        kill_cnt_q <= eff_cnt;
        kill_ext_q <= eff_ext;
      end
      // operand address: the move source while its second word waits
      if (start_two && exec_word_q[15:12] == `PFX_MOVE) begin
        file_rd_addr_o <= exec_word_q[11:0];
      end else if (state_q == ST_WAIT2 && !exec_valid_q && first_word_q[15:12] == `PFX_MOVE) begin
        file_rd_addr_o <= first_word_q[11:0];
      end else if (instr_valid_i) begin
        file_rd_addr_o <= bank_addr(instr_word_i[7:0], instr_word_i[8], bank_select_register_q);
      end
      // two-word sequencing; a lone second word falls to the nop default
      case (state_q)
        ST_NORMAL: begin
          if (start_two) begin
            state_q <= ST_WAIT2;
            first_word_q <= exec_word_q;
          end
        end
        ST_WAIT2: begin
          if (exec_valid_q) begin
            state_q <= ST_NORMAL;
          end
        end
        default: state_q <= ST_NORMAL;
      endcase
      // absolute jump and call complete on the consumed second word
      pc_abs_load_o <= consume && (first_word_q[15:8] == `PFX_GOTO || first_word_q[15:9] == `PFX_CALL);
      call_push_o <= consume && (first_word_q[15:9] == `PFX_CALL);
      if (consume) begin
        pc_target_o <= {exec_word_q[11:0], first_word_q[7:0]};
      end
      if (consume && first_word_q[15:9] == `PFX_CALL && first_word_q[8]) begin
        shadow_work_q <= working_register_q;
        shadow_bank_q <= bank_select_register_q;
        shadow_flags_q <= flags_q;
      end
      pc_rel_load_o <= rel_load;
      if (rel_load) begin
        pc_offset_o <= rel_off;
      end
      // result write-back to the data file
      file_wr_en_o <= write_file;
      file_wr_addr_o <= wr_addr;
      file_wr_data_o <= consume ? opnd : res;
      prescaler_clear_o <= write_file && prescaler_assigned_q && (wr_addr == `TIMER0_ADDR);
      if (do_mul) begin
        product_high_byte_q <= prod[15:8];
        product_low_byte_q <= prod[7:0];
      end
      // software writes win over the core in the same cycle
      if (apb_wr && paddr_i == `REG_WORK) begin
        working_register_q <= pwdata_i[7:0];
      end else if (wr_work) begin
        working_register_q <= res;
      end
      if (apb_wr && paddr_i == `REG_BANK) begin
        bank_select_register_q <= pwdata_i[3:0];
      end
      if (apb_wr && paddr_i == `REG_FLAGS) begin
        flags_q <= pwdata_i[4:0];
      end else begin
        flags_q <= (flags_q & ~fmask) | (new_flags & fmask);
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave: one wait state, error on unmapped offsets
  // ----------------------------------------------------------------
  reg [31:0] rd_mux;
  reg rd_err;

  // read data for the offset on the bus
  always @* begin
    rd_mux = `RST_DATA32;
    rd_err = 1'b0;
    case (paddr_i)
      `REG_WORK: rd_mux = {24'h000000, working_register_q};
      `REG_BANK: rd_mux = {28'h0000000, bank_select_register_q};
      `REG_FLAGS: rd_mux = {27'h0000000, flags_q};
      `REG_PRODUCT: rd_mux = {16'h0000, product_high_byte_q, product_low_byte_q};
      `REG_CONTROL: rd_mux = {31'h00000000, prescaler_assigned_q};
      `REG_SHADOW: rd_mux = {15'h0000, shadow_flags_q, shadow_bank_q, shadow_work_q};
      default: rd_err = 1'b1;
    endcase
  end

  // pready rises in the second access cycle and drops after one edge
  always @(posedge ref_clk_i) begin
    if (reset_i) begin
      pready_o <= 1'b0;
      prdata_o <= `RST_DATA32;
      pslverr_o <= 1'b0;
      prescaler_assigned_q <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      pslverr_o <= psel_i && penable_i && !pready_o && rd_err;
      prdata_o <= (psel_i && penable_i && !pready_o && !pwrite_i) ? rd_mux : `RST_DATA32;
      if (apb_wr && paddr_i == `REG_CONTROL) begin
        prescaler_assigned_q <= pwdata_i[0];
      end
    end
  end

endmodule

// >>> logic/decoder_defines.vh
// constants for the byte-op instruction decoder: opcodes, field positions,
// register offsets and reset values.
// assumes it is included by bare name from the decoder module only.
`ifndef DECODER_DEFINES_VH
`define DECODER_DEFINES_VH

// ----------------------------------------------------------------
// apb register offsets (byte addresses, one aligned word each)
// ----------------------------------------------------------------
`define REG_WORK 8'h00
`define REG_BANK 8'h04
`define REG_FLAGS 8'h08
`define REG_PRODUCT 8'h0C
`define REG_CONTROL 8'h10
`define REG_SHADOW 8'h14

// ----------------------------------------------------------------
// status flag bit positions
// ----------------------------------------------------------------
`define FLG_C 0
`define FLG_DIGIT 1
`define FLG_Z 2
`define FLG_OVF 3
`define FLG_N 4
`define MASK_NONE 5'h00
`define MASK_ALL 5'h1F
`define MASK_ZN 5'h14
`define MASK_CZN 5'h15
`define MASK_Z 5'h04

// ----------------------------------------------------------------
// reset values and plain constants
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_BANK 4'h0
`define RST_FLAGS 5'h00
`define RST_ADDR 12'h000
`define RST_WORD 16'h0000
`define RST_TARGET 20'h00000
`define RST_OFFSET 11'h000
`define RST_DATA32 32'h00000000
`define ONES8 8'hFF
`define KILL_NONE 2'h0
`define KILL_ONE 2'h1

// ----------------------------------------------------------------
// addressing: access bank split and special file addresses
// ----------------------------------------------------------------
`define ACCESS_SPLIT 8'h80
`define ACCESS_LOW_BANK 4'h0
`define ACCESS_HIGH_BANK 4'hF
`define TIMER0_ADDR 12'hF00
`define PORT_ADDR 12'hF01

// ----------------------------------------------------------------
// word prefixes for control and two-word formats
// ----------------------------------------------------------------
`define PFX_SECOND 4'hF
`define PFX_MOVE 4'hC
`define PFX_GROUP6 4'h6
`define PFX_BRANCH_ALWAYS 5'h1A
`define PFX_COND_BRANCH 5'h1C
`define PFX_CALL 7'h76
`define PFX_GOTO 8'hEF
`define PFX_LOAD_PTR 8'hEE

// ----------------------------------------------------------------
// byte-oriented opcodes, word bits 15:10
// ----------------------------------------------------------------
`define OP_MISC 6'h00
`define OP_DECF 6'h01
`define OP_LIT_LAST 6'h03
`define OP_IOR 6'h04
`define OP_AND 6'h05
`define OP_XOR 6'h06
`define OP_COMPLEMENT_FILE 6'h07
`define OP_ADDC 6'h08
`define OP_ADD 6'h09
`define OP_INCF 6'h0A
`define OP_DECSZ 6'h0B
`define OP_RRC 6'h0C
`define OP_RLC 6'h0D
`define OP_SWAP 6'h0E
`define OP_INCSZ 6'h0F
`define OP_RRN 6'h10
`define OP_RLN 6'h11
`define OP_INCSNZ 6'h12
`define OP_DECSNZ 6'h13
`define OP_MOVF 6'h14
`define OP_SUBTRACT_FILE_FROM_WORK_BORROW 6'h15
`define OP_SUBTRACT_WORK_FROM_FILE_BORROW 6'h16
`define OP_SUBTRACT_WORK_FROM_FILE 6'h17

// sub-opcodes of the 0110 group, word bits 11:9
`define G6_CPLT 3'h0
`define G6_CPEQ 3'h1
`define G6_CPGT 3'h2
`define G6_TSTZ 3'h3
`define G6_SETF 3'h4
`define G6_CLRF 3'h5
`define G6_NEGF 3'h6
`define G6_MOVWF 3'h7

`endif

// >>> tb/decoder_checker_assertions.sv
// port checker for the byte-op decoder
// assumes words take effect at the ports two edges after acceptance
`timescale 1ns/100ps
module decoder_checker (
  input wire ref_clk_i, input wire reset_i, input wire [15:0] instr_word_i, input wire instr_valid_i,
  input wire file_wr_en_o, input wire [11:0] file_wr_addr_o, input wire psel_i, input wire penable_i,
  input wire [7:0] paddr_i, input wire pready_o, input wire pslverr_o, input wire pc_rel_load_o,
  input wire [10:0] pc_offset_o, input wire pc_abs_load_o, input wire [19:0] pc_target_o, input wire nop_cycle_o
);
  // -----------------------------
  // word history
  // -----------------------------
  logic [15:0] w1, w2, w3;
  logic v1, v2;
  // history lines up each output with the word that caused it
  always @(posedge ref_clk_i) begin
    w1 <= instr_word_i;
    w2 <= w1;
    w3 <= w2;
    v1 <= instr_valid_i;
    v2 <= v1;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_access; psel_i && penable_i && !pready_o; endsequence
  sequence s_add_write; file_wr_en_o && v2 && w2[15:10] == 6'h09; endsequence
  a_ready_wait: assert property (s_access |=> pready_o) else $error("pready missing");
  a_err_unmapped: assert property (pready_o && paddr_i > 8'h14 |-> pslverr_o) else $error("no slverr");
  a_bra_offset: assert property (pc_rel_load_o && w2[15:11] == 5'h1A |-> pc_offset_o == w2[10:0])
    else $error("bad branch offset");
  a_cond_offset: assert property (pc_rel_load_o && w2[15:11] == 5'h1C |-> pc_offset_o[7:0] == w2[7:0])
    else $error("bad cond offset");
  a_branch_flush: assert property (pc_rel_load_o |-> ##[0:1] nop_cycle_o) else $error("no flush");
  a_goto_target: assert property (pc_abs_load_o |-> pc_target_o == {w2[11:0], w3[7:0]})
    else $error("bad target");
  a_add_dest: assert property (s_add_write |-> w2[9] && file_wr_addr_o[7:0] == w2[7:0])
    else $error("bad add dest");
  a_access_bank: assert property ((s_add_write and !w2[8]) |-> file_wr_addr_o[11:8] == (w2[7] ? 4'hF : 4'h0))
    else $error("bad access bank");
endmodule
bind byte_op_instruction_decoder decoder_checker chk_u (.*);

// >>> tb/file_model.sv
// data file model for the decoder bench
// assumes reads are answered in the same cycle, writes land on the clock
`timescale 1ns/100ps
module file_model (
  input wire logic ref_clk_i,
  input wire logic [11:0] file_rd_addr_o,
  output logic [7:0] file_rd_data_i,
  input wire logic file_wr_en_o,
  input wire logic [11:0] file_wr_addr_o,
  input wire logic [7:0] file_wr_data_o
);
  logic [7:0] mem [0:4095];
  // combinational read, the decoder samples it in its execute cycle
  assign file_rd_data_i = mem[file_rd_addr_o];
  always @(posedge ref_clk_i) if (file_wr_en_o) mem[file_wr_addr_o] <= file_wr_data_o;
endmodule

// >>> tb/tb_byte_op_instruction_decoder.sv
// self-checking bench for the byte-op decoder
// assumes the file model answers reads, words are fed back to back
`timescale 1ns/100ps
module tb_byte_op_instruction_decoder;
  logic ref_clk_i = 0, reset_i = 1, instr_valid_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [15:0] instr_word_i = 16'h0000;
  logic [7:0] paddr_i = 8'h00, port_pins_i = 8'h5A, w, f, s;
  logic [31:0] pwdata_i = 32'h00000000;
  wire [31:0] prdata_o;
  wire pready_o, pslverr_o, file_wr_en_o, pc_abs_load_o, pc_rel_load_o, call_push_o, nop_cycle_o, prescaler_clear_o;
  wire [11:0] file_rd_addr_o, file_wr_addr_o;
  wire [7:0] file_wr_data_o, file_rd_data_i;
  wire [19:0] pc_target_o;
  wire [10:0] pc_offset_o;
  integer fail_count = 0, samples_checked = 0, cyc = 0, pcnt = 0, ncnt = 0, seed = 32'hd983;
  logic [15:0] p;
  logic [19:0] wq[$];
  logic [32:0] rq[$];
  always #50 ref_clk_i = ~ref_clk_i;
  byte_op_instruction_decoder dut_u (.*);
  file_model fm_u (.*);
  task chk(input string n, input [32:0] e, input [32:0] g);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // -----------------------------
  // monitor: oldest note against each result
  // -----------------------------
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
    if (prescaler_clear_o) pcnt++;
    if (nop_cycle_o) ncnt++;
    if (file_wr_en_o) begin
      chk("file write", wq.size() ? wq.pop_front() : 33'h1FFFFFFFF, {file_wr_addr_o, file_wr_data_o});
    end
    if (pready_o && !pwrite_i) chk("apb read", rq.pop_front(), {pslverr_o, prdata_o});
  end
  // apb master, read expectations noted when the request starts
  task apb(input x, input [7:0] a, input [31:0] d, input [32:0] e);
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= x;
    paddr_i <= a;
    pwdata_i <= d;
    if (!x) rq.push_back(e);
    @(posedge ref_clk_i);
    penable_i <= 1;
    @(posedge ref_clk_i);
    while (!pready_o) @(posedge ref_clk_i);
    psel_i <= 0;
    penable_i <= 0;
    // let the release reach an edge so the next call never re-drives it in this step
    @(posedge ref_clk_i);
  endtask
  task op(input [15:0] x);
    instr_word_i <= x;
    instr_valid_i <= 1;
    @(posedge ref_clk_i);
  endtask
  task idle;
    instr_valid_i <= 0;
    repeat (5) @(posedge ref_clk_i);
  endtask
  // -----------------------------
  // main sequence
  // -----------------------------
  initial begin
    repeat (16) @(posedge ref_clk_i);
    reset_i <= 0;
    @(posedge ref_clk_i);
    w = $random(seed);
    f = $random(seed);
    s = w + f;
    p = w * s;
    fm_u.mem[12'h010] = f;
    apb(1, 8'h00, {24'h0, w}, 0);
    apb(0, 8'h40, 0, {1'b1, 32'h0});
    wq.push_back({12'h010, s});
    op(16'h2610);
    op(16'h0210);
    op(16'h1410);
    idle();
    apb(0, 8'h0C, 0, {17'h0, p});
    apb(0, 8'h00, 0, {25'h0, w & s});
    $display("test alu done");
    apb(1, 8'h08, 32'h4, 0);
    op({5'h1A, 11'($random(seed))});
    op(16'h2620);
    op({8'hE0, 8'($random(seed))});
    op(16'h2620);
    op({8'hEF, 8'($random(seed))});
    op({4'hF, 12'($random(seed))});
    op(16'hF123);
    idle();
    s = 8'($random(seed));
    port_pins_i <= s;
    apb(1, 8'h10, 32'h1, 0);
    apb(1, 8'h04, 32'hF, 0);
    wq.push_back({12'hF00, 8'h00});
    op(16'h6B00);
    idle();
    chk("prescaler clears", 1, pcnt);
    // move the port pins to 0x020, then skip a two-word pair and subtract to zero
    wq.push_back({12'h020, s});
    op(16'hCF01);
    op(16'hF020);
    idle();
    apb(1, 8'h00, {24'h0, s}, 0);
    wq.push_back({12'h020, 8'h00});
    op(16'h6220);
    op(16'hC030);
    op(16'hF040);
    op(16'h5E20);
    idle();
    apb(0, 8'h08, 0, {28'h0, 5'h07});
    chk("nop cycles", 4, ncnt);
    $display("test flow done");
    close_out();
  end
endmodule
